//--- rtl/alu_consts.svh
// Constants for the integer execution datapath.
// Function
// - AND, OR, XOR, NOR on two registers.
// - Low logical immediates are zero-extended first.
// - High logical immediates fill the upper half.
// - Add, subtract, multiply, signed and unsigned divide.
// - Add, subtract, multiply take signed immediates.
// - High product words, signed or unsigned.
// - High products need no preceding low multiply.
// - Mixed high product serves wide signed multiplies.
// - Register move copies the source unchanged.
// - Signed immediate load is sign-extended.
// - Immediate loads to low or upper half.
// - Comparisons write one if true, else zero.
// - Equal, unequal, signed and unsigned orderings.
// - Compare immediates sign- or zero-extended by kind.
`ifndef ALU_CONSTS_SVH
`define ALU_CONSTS_SVH

`define ALU_DATA_W      32
`define ALU_IMM_W       16
`define ALU_DEST_W      5
`define ALU_DATA_RST    32'h0000_0000
`define ALU_DEST_RST    5'h00
`define ALU_TRUE        32'h0000_0001
`define ALU_FALSE       32'h0000_0000
`define ALU_HALF_ZERO   16'h0000
`define ALU_DIV_CNT_W   6
`define ALU_DIV_CNT_RST 6'h00
`define ALU_DIV_CNT_ONE 6'h01

`endif

//--- rtl/alu_pkg.sv
// Operation and state types of the integer execution datapath.
`default_nettype none
package alu_pkg;

	typedef enum logic [5:0] {
		OP_AND = 6'h00, OP_OR = 6'h01, OP_XOR = 6'h02, OP_NOR = 6'h03,
		OP_AND_IMM = 6'h04, OP_OR_IMM = 6'h05, OP_XOR_IMM = 6'h06,
		OP_AND_HI = 6'h07, OP_OR_HI = 6'h08, OP_XOR_HI = 6'h09,
		OP_ADD = 6'h0a, OP_SUB = 6'h0b, OP_MUL = 6'h0c,
		OP_DIV_S = 6'h0d, OP_DIV_U = 6'h0e,
		OP_ADD_IMM = 6'h0f, OP_SUB_IMM = 6'h10, OP_MUL_IMM = 6'h11,
		OP_MULH_SS = 6'h12, OP_MULH_UU = 6'h13, OP_MULH_SU = 6'h14,
		OP_MOVE = 6'h15, OP_LOAD_SIMM = 6'h16, OP_LOAD_LO = 6'h17, OP_LOAD_HI = 6'h18,
		OP_CMP_EQ = 6'h19, OP_CMP_NE = 6'h1a, OP_CMP_GE = 6'h1b, OP_CMP_GEU = 6'h1c,
		OP_CMP_GT = 6'h1d, OP_CMP_GTU = 6'h1e, OP_CMP_LE = 6'h1f, OP_CMP_LEU = 6'h20,
		OP_CMP_LT = 6'h21, OP_CMP_LTU = 6'h22,
		OP_CMPI_EQ = 6'h23, OP_CMPI_NE = 6'h24, OP_CMPI_GE = 6'h25, OP_CMPI_GEU = 6'h26,
		OP_CMPI_GT = 6'h27, OP_CMPI_GTU = 6'h28, OP_CMPI_LE = 6'h29, OP_CMPI_LEU = 6'h2a,
		OP_CMPI_LT = 6'h2b, OP_CMPI_LTU = 6'h2c
	} alu_op_e;

	typedef enum logic [0:0] {
		ST_IDLE   = 1'b0,
		ST_DIVIDE = 1'b1
	} alu_state_e;

endpackage
`default_nettype wire

//--- rtl/div_if.sv
// Handshake between the datapath and its sequential divider.
`default_nettype none
interface div_if #(
	parameter int WIDTH = 32
);
	logic             start;
	logic             signed_mode;
	logic [WIDTH-1:0] dividend;
	logic [WIDTH-1:0] divisor;
	logic             done;
	logic [WIDTH-1:0] quotient;

	modport requester (
		output start,
		output signed_mode,
		output dividend,
		output divisor,
		input  done,
		input  quotient
	);

	modport divider (
		input  start,
		input  signed_mode,
		input  dividend,
		input  divisor,
		output done,
		output quotient
	);
endinterface
`default_nettype wire

//--- rtl/alu_divider.sv
// Sequential restoring divider, one quotient bit per clock.
`include "alu_consts.svh"
`default_nettype none
module alu_divider #(
	parameter int WIDTH = `ALU_DATA_W
) (
	input  wire logic clk_sys_i,
	input  wire logic arst_n_i,
	div_if.divider    port_d
);

	initial begin
		if (WIDTH < 2 || WIDTH >= (1 << `ALU_DIV_CNT_W))
			$error("alu_divider: WIDTH out of range");
	end

	logic [WIDTH:0]          rem_reg;
	logic [WIDTH:0]          rem_next;
	logic [WIDTH-1:0]        quo_reg;
	logic [WIDTH-1:0]        quo_next;
	logic [WIDTH-1:0]        dsr_reg;
	logic [WIDTH-1:0]        dsr_next;
	logic                    neg_reg;
	logic                    neg_next;
	logic                    done_reg;
	logic                    done_next;
	logic [`ALU_DIV_CNT_W-1:0] cnt_reg;
	logic [`ALU_DIV_CNT_W-1:0] cnt_next;
	logic [WIDTH:0]          rem_sh;
	logic [WIDTH:0]          trial;
	logic                    a_neg;
	logic                    b_neg;

	// Signed division works on magnitudes and restores the sign at the end.
	always_comb begin
		a_neg     = port_d.signed_mode & port_d.dividend[WIDTH-1];
		b_neg     = port_d.signed_mode & port_d.divisor[WIDTH-1];
		rem_sh    = {rem_reg[WIDTH-1:0], quo_reg[WIDTH-1]};
		trial     = rem_sh - {1'b0, dsr_reg};
		rem_next  = rem_reg;
		quo_next  = quo_reg;
		dsr_next  = dsr_reg;
		neg_next  = neg_reg;
		cnt_next  = cnt_reg;
		done_next = 1'b0;
		if (port_d.start) begin
			rem_next = '0;
			quo_next = a_neg ? WIDTH'(-port_d.dividend) : port_d.dividend;
			dsr_next = b_neg ? WIDTH'(-port_d.divisor) : port_d.divisor;
			neg_next = a_neg ^ b_neg;
			cnt_next = `ALU_DIV_CNT_W'(WIDTH);
		end else if (cnt_reg != `ALU_DIV_CNT_RST) begin
			// A zero divisor simply runs through; every trial succeeds and the quotient magnitude comes out all ones.
			if (!trial[WIDTH]) begin
				rem_next = trial;
				quo_next = {quo_reg[WIDTH-2:0], 1'b1};
			end else begin
				rem_next = rem_sh;
				quo_next = {quo_reg[WIDTH-2:0], 1'b0};
			end
			cnt_next  = cnt_reg - `ALU_DIV_CNT_ONE;
			done_next = (cnt_reg == `ALU_DIV_CNT_ONE);
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rem_reg  <= '0;
			quo_reg  <= '0;
			dsr_reg  <= '0;
			neg_reg  <= 1'b0;
			done_reg <= 1'b0;
			cnt_reg  <= `ALU_DIV_CNT_RST;
		end else begin
			rem_reg  <= rem_next;
			quo_reg  <= quo_next;
			dsr_reg  <= dsr_next;
			neg_reg  <= neg_next;
			done_reg <= done_next;
			cnt_reg  <= cnt_next;
		end
	end

	assign port_d.done     = done_reg;
	assign port_d.quotient = neg_reg ? WIDTH'(-quo_reg) : quo_reg;

endmodule // alu_divider
`default_nettype wire

//--- rtl/integer_alu.sv
// Integer execution datapath: logic, arithmetic, moves and compares.
`include "alu_consts.svh"
`default_nettype none
module integer_alu #(
	parameter int DATA_W = `ALU_DATA_W,
	parameter int IMM_W  = `ALU_IMM_W,
	parameter int DEST_W = `ALU_DEST_W
) (
	input  wire logic               clk_sys_i,
	input  wire logic               arst_n_i,
	input  wire logic               op_valid_i,
	input  wire alu_pkg::alu_op_e   op_code_i,
	input  wire logic [DATA_W-1:0]  opnd_a_i,
	input  wire logic [DATA_W-1:0]  opnd_b_i,
	input  wire logic [IMM_W-1:0]   imm_i,
	input  wire logic [DEST_W-1:0]  dest_idx_i,
	output logic                    ready_o,
	output logic                    result_valid_o,
	output logic [DATA_W-1:0]       result_o,
	output logic [DEST_W-1:0]       result_dest_o
);

	initial begin
		if (DATA_W != 2 * IMM_W)
			$error("integer_alu: DATA_W must be twice IMM_W");
		if (DATA_W != `ALU_DATA_W || DEST_W < 1)
			$error("integer_alu: unsupported width");
	end

	localparam int PW = 2 * DATA_W;

	div_if #(.WIDTH(DATA_W)) div_link ();

	alu_divider #(
		.WIDTH (DATA_W)
	) u_divider (
		.clk_sys_i (clk_sys_i),
		.arst_n_i  (arst_n_i),
		.port_d    (div_link.divider)
	);

	alu_pkg::alu_state_e state_reg;
	alu_pkg::alu_state_e state_next;
	logic                ready_reg;
	logic                ready_next;
	logic                valid_reg;
	logic                valid_next;
	logic [DATA_W-1:0]   result_reg;
	logic [DATA_W-1:0]   result_next;
	logic [DEST_W-1:0]   dest_reg;
	logic [DEST_W-1:0]   dest_next;

	logic [DATA_W-1:0]   imm_zext;
	logic [DATA_W-1:0]   imm_sext;
	logic [DATA_W-1:0]   imm_high;
	logic [DATA_W-1:0]   cmp_b;
	logic                cmp_eq;
	logic                cmp_lt_s;
	logic                cmp_lt_u;
	logic                cmp_true;
	logic                is_cmp;
	logic                is_div;
	logic [DATA_W-1:0]   mul_b;
	logic [DATA_W-1:0]   prod_lo;
	logic [PW-1:0]       prod_ss;
	logic [PW-1:0]       prod_uu;
	logic [PW+1:0]       prod_su;
	logic [DATA_W-1:0]   fast_result;
	logic                accept;

	// Immediate forms of the second operand.
	always_comb begin
		imm_zext = {`ALU_HALF_ZERO, imm_i};
		imm_sext = {{IMM_W{imm_i[IMM_W-1]}}, imm_i};
		imm_high = {imm_i, `ALU_HALF_ZERO};
	end

	// Every product is formed from the operands alone; no earlier multiply is needed.
	always_comb begin
		mul_b   = (op_code_i == alu_pkg::OP_MUL_IMM) ? imm_sext : opnd_b_i;
		prod_lo = DATA_W'(opnd_a_i * mul_b);
		prod_ss = PW'($signed(opnd_a_i) * $signed(opnd_b_i));
		prod_uu = PW'({{DATA_W{1'b0}}, opnd_a_i} * {{DATA_W{1'b0}}, opnd_b_i});
		prod_su = (PW + 2)'($signed({opnd_a_i[DATA_W-1], opnd_a_i})
			* $signed({1'b0, opnd_b_i}));
	end

	// Comparator: register or immediate second operand, extension by signedness.
	always_comb begin
		unique case (op_code_i)
			alu_pkg::OP_CMPI_EQ,
			alu_pkg::OP_CMPI_NE,
			alu_pkg::OP_CMPI_GE,
			alu_pkg::OP_CMPI_GT,
			alu_pkg::OP_CMPI_LE,
			alu_pkg::OP_CMPI_LT: begin
				cmp_b = imm_sext;
			end
			alu_pkg::OP_CMPI_GEU,
			alu_pkg::OP_CMPI_GTU,
			alu_pkg::OP_CMPI_LEU,
			alu_pkg::OP_CMPI_LTU: begin
				cmp_b = imm_zext;
			end
			default: begin
				cmp_b = opnd_b_i;
			end
		endcase
		cmp_eq   = (opnd_a_i == cmp_b);
		cmp_lt_s = ($signed(opnd_a_i) < $signed(cmp_b));
		cmp_lt_u = (opnd_a_i < cmp_b);
	end

	// Relation select; the register and immediate forms of each relation share one arm.
	always_comb begin
		is_cmp   = 1'b1;
		cmp_true = 1'b0;
		case (op_code_i)
			alu_pkg::OP_CMP_EQ,
			alu_pkg::OP_CMPI_EQ: begin
				cmp_true = cmp_eq;
			end
			alu_pkg::OP_CMP_NE,
			alu_pkg::OP_CMPI_NE: begin
				cmp_true = !cmp_eq;
			end
			alu_pkg::OP_CMP_GE,
			alu_pkg::OP_CMPI_GE: begin
				cmp_true = !cmp_lt_s;
			end
			alu_pkg::OP_CMP_GEU,
			alu_pkg::OP_CMPI_GEU: begin
				cmp_true = !cmp_lt_u;
			end
			alu_pkg::OP_CMP_GT,
			alu_pkg::OP_CMPI_GT: begin
				cmp_true = !cmp_lt_s && !cmp_eq;
			end
			alu_pkg::OP_CMP_GTU,
			alu_pkg::OP_CMPI_GTU: begin
				cmp_true = !cmp_lt_u && !cmp_eq;
			end
			alu_pkg::OP_CMP_LE,
			alu_pkg::OP_CMPI_LE: begin
				cmp_true = cmp_lt_s || cmp_eq;
			end
			alu_pkg::OP_CMP_LEU,
			alu_pkg::OP_CMPI_LEU: begin
				cmp_true = cmp_lt_u || cmp_eq;
			end
			alu_pkg::OP_CMP_LT,
			alu_pkg::OP_CMPI_LT: begin
				cmp_true = cmp_lt_s;
			end
			alu_pkg::OP_CMP_LTU,
			alu_pkg::OP_CMPI_LTU: begin
				cmp_true = cmp_lt_u;
			end
			default: begin
				is_cmp = 1'b0;
			end
		endcase
	end

	// Single-cycle result for everything except division.
	always_comb begin
		is_div      = 1'b0;
		fast_result = `ALU_DATA_RST;
		case (op_code_i)
			alu_pkg::OP_AND: begin
				fast_result = opnd_a_i & opnd_b_i;
			end
			alu_pkg::OP_OR: begin
				fast_result = opnd_a_i | opnd_b_i;
			end
			alu_pkg::OP_XOR: begin
				fast_result = opnd_a_i ^ opnd_b_i;
			end
			alu_pkg::OP_NOR: begin
				fast_result = ~(opnd_a_i | opnd_b_i);
			end
			alu_pkg::OP_AND_IMM: begin
				fast_result = opnd_a_i & imm_zext;
			end
			alu_pkg::OP_OR_IMM: begin
				fast_result = opnd_a_i | imm_zext;
			end
			alu_pkg::OP_XOR_IMM: begin
				fast_result = opnd_a_i ^ imm_zext;
			end
			alu_pkg::OP_AND_HI: begin
				fast_result = opnd_a_i & imm_high;
			end
			alu_pkg::OP_OR_HI: begin
				fast_result = opnd_a_i | imm_high;
			end
			alu_pkg::OP_XOR_HI: begin
				fast_result = opnd_a_i ^ imm_high;
			end
			alu_pkg::OP_ADD: begin
				fast_result = DATA_W'(opnd_a_i + opnd_b_i);
			end
			alu_pkg::OP_SUB: begin
				fast_result = DATA_W'(opnd_a_i - opnd_b_i);
			end
			alu_pkg::OP_ADD_IMM: begin
				fast_result = DATA_W'(opnd_a_i + imm_sext);
			end
			alu_pkg::OP_SUB_IMM: begin
				fast_result = DATA_W'(opnd_a_i - imm_sext);
			end
			alu_pkg::OP_MUL,
			alu_pkg::OP_MUL_IMM: begin
				fast_result = prod_lo;
			end
			alu_pkg::OP_MULH_SS: begin
				fast_result = prod_ss[PW-1:DATA_W];
			end
			alu_pkg::OP_MULH_UU: begin
				fast_result = prod_uu[PW-1:DATA_W];
			end
			alu_pkg::OP_MULH_SU: begin
				fast_result = prod_su[PW-1:DATA_W];
			end
			alu_pkg::OP_MOVE: begin
				fast_result = opnd_a_i;
			end
			alu_pkg::OP_LOAD_SIMM: begin
				fast_result = imm_sext;
			end
			alu_pkg::OP_LOAD_LO: begin
				fast_result = imm_zext;
			end
			alu_pkg::OP_LOAD_HI: begin
				fast_result = imm_high;
			end
			alu_pkg::OP_DIV_S,
			alu_pkg::OP_DIV_U: begin
				is_div = 1'b1;
			end
			default: begin
				fast_result = is_cmp ? (cmp_true ? `ALU_TRUE : `ALU_FALSE)
					: `ALU_DATA_RST;
			end
		endcase
	end

	assign accept = op_valid_i && ready_reg;

	// Divider request is launched in the cycle the operation is accepted.
	always_comb begin
		div_link.start       = accept && is_div && (state_reg == alu_pkg::ST_IDLE);
		div_link.signed_mode = (op_code_i == alu_pkg::OP_DIV_S);
		div_link.dividend    = opnd_a_i;
		div_link.divisor     = opnd_b_i;
	end

	// Sequencer: one-cycle results, or a stall while the divider runs.
	always_comb begin
		state_next  = state_reg;
		ready_next  = ready_reg;
		valid_next  = 1'b0;
		result_next = result_reg;
		dest_next   = dest_reg;
		case (state_reg)
			alu_pkg::ST_IDLE: begin
				if (accept) begin
					dest_next = dest_idx_i;
					if (is_div) begin
						state_next = alu_pkg::ST_DIVIDE;
						ready_next = 1'b0;
					end else begin
						result_next = fast_result;
						valid_next  = 1'b1;
					end
				end
			end
			alu_pkg::ST_DIVIDE: begin
				if (div_link.done) begin
					result_next = div_link.quotient;
					valid_next  = 1'b1;
					ready_next  = 1'b1;
					state_next  = alu_pkg::ST_IDLE;
				end
			end
			default: begin
				state_next = alu_pkg::ST_IDLE;
				ready_next = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg  <= alu_pkg::ST_IDLE;
			ready_reg  <= 1'b1;
			valid_reg  <= 1'b0;
			result_reg <= `ALU_DATA_RST;
			dest_reg   <= `ALU_DEST_RST;
		end else begin
			state_reg  <= state_next;
			ready_reg  <= ready_next;
			valid_reg  <= valid_next;
			result_reg <= result_next;
			dest_reg   <= dest_next;
		end
	end

	assign ready_o        = ready_reg;
	assign result_valid_o = valid_reg;
	assign result_o       = result_reg;
	assign result_dest_o  = dest_reg;

endmodule // integer_alu
`default_nettype wire

//--- sim/regfile_sink.sv
// Write-back register file model that takes the datapath results.
`default_nettype none
module regfile_sink #(
	parameter int DATA_W = 32,
	parameter int DEST_W = 5
) (
	input  wire logic              clk_sys_i,
	input  wire logic              wr_en_i,
	input  wire logic [DEST_W-1:0] wr_idx_i,
	input  wire logic [DATA_W-1:0] wr_data_i,
	input  wire logic [DEST_W-1:0] rd_idx_i,
	output logic      [DATA_W-1:0] rd_data_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [DATA_W-1:0] regs [2**DEST_W];

	// A result is written at the edge where its pulse is seen.
	always @(posedge clk_sys_i) begin
		if (wr_en_i === 1'b1) begin
			regs[wr_idx_i] <= wr_data_i;
		end
	end
	assign rd_data_o = regs[rd_idx_i];
endmodule // regfile_sink
`default_nettype wire

//--- sim/integer_alu_chk.sv
// Concurrent checks on the integer datapath ports.
`default_nettype none
module integer_alu_chk #(
	parameter int DATA_W = 32,
	parameter int IMM_W  = 16,
	parameter int DEST_W = 5
) (
	input wire logic              clk_sys_i,
	input wire logic              arst_n_i,
	input wire logic              op_valid_i,
	input wire alu_pkg::alu_op_e  op_code_i,
	input wire logic [DATA_W-1:0] opnd_a_i,
	input wire logic [DATA_W-1:0] opnd_b_i,
	input wire logic [IMM_W-1:0]  imm_i,
	input wire logic [DEST_W-1:0] dest_idx_i,
	input wire logic              ready_o,
	input wire logic              result_valid_o,
	input wire logic [DATA_W-1:0] result_o,
	input wire logic [DEST_W-1:0] result_dest_o
);
	timeunit 1ns;
	timeprecision 1ns;
	wire logic take   = op_valid_i && ready_o;
	wire logic is_div = op_code_i inside {alu_pkg::OP_DIV_S, alu_pkg::OP_DIV_U};

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!arst_n_i);

	sequence s_take_fast;
		take && !is_div;
	endsequence
	sequence s_take_div;
		take && is_div;
	endsequence
	sequence s_take_op(alu_pkg::alu_op_e op);
		take && op_code_i == op;
	endsequence

	fast_result_a: assert property (s_take_fast |=> result_valid_o && result_dest_o == $past(dest_idx_i))
		else $error("fast result missing or wrong destination");
	div_busy_a: assert property (s_take_div |=> !ready_o [*8])
		else $error("ready high during divide");
	div_done_a: assert property (s_take_div |-> ##[33:35] result_valid_o)
		else $error("divide result late");
	cmp_bool_a: assert property (take && op_code_i inside {[alu_pkg::OP_CMP_EQ:alu_pkg::OP_CMPI_LTU]} |=> result_o[DATA_W-1:1] == '0)
		else $error("compare result not one or zero");
	move_copy_a: assert property (s_take_op(alu_pkg::OP_MOVE) |=> result_o == $past(opnd_a_i))
		else $error("move result differs from source");
	load_simm_a: assert property (s_take_op(alu_pkg::OP_LOAD_SIMM) |=> result_o == {{16{$past(imm_i[15])}}, $past(imm_i)})
		else $error("signed immediate load wrong");
	load_upper_a: assert property (s_take_op(alu_pkg::OP_LOAD_HI) |=> result_o == {$past(imm_i), 16'h0000})
		else $error("upper immediate load wrong");
	and_imm_a: assert property (s_take_op(alu_pkg::OP_AND_IMM) |=> result_o == ($past(opnd_a_i) & {16'h0000, $past(imm_i)}))
		else $error("low immediate and wrong");
	or_high_a: assert property (s_take_op(alu_pkg::OP_OR_HI) |=> result_o == ($past(opnd_a_i) | {$past(imm_i), 16'h0000}))
		else $error("high immediate or wrong");
	nor_reg_a: assert property (s_take_op(alu_pkg::OP_NOR) |=> result_o == ~($past(opnd_a_i) | $past(opnd_b_i)))
		else $error("register nor wrong");
	div_seen_c: cover property (s_take_div);
endmodule // integer_alu_chk
`default_nettype wire

//--- sim/test_integer_alu.sv
// Self-checking bench for the integer execution datapath.
`default_nettype none
module test_integer_alu;
	timeunit 1ns;
	timeprecision 1ns;
	logic             clk_sys_i, arst_n_i, op_valid_i, ready_o, result_valid_o;
	alu_pkg::alu_op_e op_code_i, rop;
	logic [31:0]      opnd_a_i, opnd_b_i, result_o, rd_data, ra, rb;
	logic [15:0]      imm_i, ri;
	logic [4:0]       dest_idx_i, result_dest_o;
	int               bad_count, total_checks, seed, k, n;
	logic [31:0]      exp_q [$];
	logic [31:0]      cor_a [3] = '{32'h8000_0000, 32'hFFFF_FFFF, 32'h0000_1234};
	logic [31:0]      cor_b [3] = '{32'h7FFF_FFFF, 32'h8000_0000, 32'h0000_1234};
	logic [15:0]      cor_i [3] = '{16'h8000, 16'hFFFF, 16'h1234};

	integer_alu u_integer_alu (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
		.op_valid_i(op_valid_i), .op_code_i(op_code_i), .opnd_a_i(opnd_a_i),
		.opnd_b_i(opnd_b_i), .imm_i(imm_i), .dest_idx_i(dest_idx_i), .ready_o(ready_o),
		.result_valid_o(result_valid_o), .result_o(result_o), .result_dest_o(result_dest_o));
	regfile_sink u_regfile_sink (.clk_sys_i(clk_sys_i), .wr_en_i(result_valid_o),
		.wr_idx_i(result_dest_o), .wr_data_i(result_o), .rd_idx_i(dest_idx_i),
		.rd_data_o(rd_data));

	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end

	// Reference result of one operation, worked out independently.
	function automatic logic [31:0] calc(input alu_pkg::alu_op_e op, input logic [31:0] a,
		input logic [31:0] b, input logic [15:0] i);
		logic [31:0] s, z, h, y;
		logic [63:0] pss, puu, psu;
		logic        c;
		int          r;
		s = {{16{i[15]}}, i};
		z = {16'h0000, i};
		h = {i, 16'h0000};
		pss = {{32{a[31]}}, a} * {{32{b[31]}}, b};
		puu = {32'h0000_0000, a} * {32'h0000_0000, b};
		psu = {{32{a[31]}}, a} * {32'h0000_0000, b};
		r = (op - alu_pkg::OP_CMP_EQ) % 10;
		y = (op >= alu_pkg::OP_CMPI_EQ) ? ((r > 1 && r[0]) ? z : s) : b;
		case (op)
			alu_pkg::OP_AND: return a & b;
			alu_pkg::OP_OR: return a | b;
			alu_pkg::OP_XOR: return a ^ b;
			alu_pkg::OP_NOR: return ~(a | b);
			alu_pkg::OP_AND_IMM: return a & z;
			alu_pkg::OP_OR_IMM: return a | z;
			alu_pkg::OP_XOR_IMM: return a ^ z;
			alu_pkg::OP_AND_HI: return a & h;
			alu_pkg::OP_OR_HI: return a | h;
			alu_pkg::OP_XOR_HI: return a ^ h;
			alu_pkg::OP_ADD: return a + b;
			alu_pkg::OP_SUB: return a - b;
			alu_pkg::OP_MUL: return a * b;
			alu_pkg::OP_DIV_S: return $signed(a) / $signed(b);
			alu_pkg::OP_DIV_U: return a / b;
			alu_pkg::OP_ADD_IMM: return a + s;
			alu_pkg::OP_SUB_IMM: return a - s;
			alu_pkg::OP_MUL_IMM: return a * s;
			alu_pkg::OP_MULH_SS: return pss[63:32];
			alu_pkg::OP_MULH_UU: return puu[63:32];
			alu_pkg::OP_MULH_SU: return psu[63:32];
			alu_pkg::OP_MOVE: return a;
			alu_pkg::OP_LOAD_SIMM: return s;
			alu_pkg::OP_LOAD_LO: return z;
			alu_pkg::OP_LOAD_HI: return h;
			default: begin
				case (r)
					0: c = a == y;
					1: c = a != y;
					2: c = $signed(a) >= $signed(y);
					3: c = a >= y;
					4: c = $signed(a) > $signed(y);
					5: c = a > y;
					6: c = $signed(a) <= $signed(y);
					7: c = a <= y;
					8: c = $signed(a) < $signed(y);
					default: c = a < y;
				endcase
				return {31'h0000_0000, c};
			end
		endcase
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic test_done;
		$display("checks=%0d mismatches=%0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Waits at falling edges for ready (sel=0) or a result pulse (sel=1).
	task automatic wait_for(input bit sel);
		int w;
		w = 0;
		@(negedge clk_sys_i);
		while (((sel ? result_valid_o : ready_o) !== 1'b1) && w < 50) begin
			@(negedge clk_sys_i);
			w++;
		end
		if (w >= 50) begin
			bad_count++;
			test_done();
		end
	endtask

	// One operation at a time, checked at the port and in the register file.
	task automatic run_op(input alu_pkg::alu_op_e op, input logic [31:0] a,
		input logic [31:0] b, input logic [15:0] i, input logic [4:0] d);
		@(posedge clk_sys_i);
		op_valid_i <= 1'b1;
		op_code_i <= op;
		opnd_a_i <= a;
		opnd_b_i <= b;
		imm_i <= i;
		dest_idx_i <= d;
		wait_for(1'b0);
		@(posedge clk_sys_i);
		op_valid_i <= 1'b0;
		wait_for(1'b1);
		check(result_o, calc(op, a, b, i));
		check(32'(result_dest_o), 32'(d));
		@(negedge clk_sys_i);
		check(rd_data, calc(op, a, b, i));
	endtask

	initial begin
		seed = 53522;
		arst_n_i = 1'b0;
		op_valid_i = 1'b0;
		op_code_i = alu_pkg::OP_AND;
		opnd_a_i = 32'h0000_0000;
		opnd_b_i = 32'h0000_0000;
		imm_i = 16'h0000;
		dest_idx_i = 5'h00;
		repeat (4) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		for (k = 0; k < 135; k++) begin
			rop = alu_pkg::alu_op_e'(6'(k % 45));
			ri = cor_i[k / 45];
			if (rop inside {alu_pkg::OP_CMPI_EQ, alu_pkg::OP_CMPI_NE}) ri[15] = 1'b0;
			run_op(rop, cor_a[k / 45], cor_b[k / 45], ri, 5'(k));
		end
		run_op(alu_pkg::OP_DIV_S, 32'hFFFF_FFF9, 32'h0000_0002, 16'h0000, 5'h1F);
		// Back-to-back random stream; high products come in any order.
		for (k = 0; k < 300; k++) begin
			@(posedge clk_sys_i);
			rop = alu_pkg::alu_op_e'(6'($unsigned($random(seed)) % 45));
			if (rop inside {alu_pkg::OP_DIV_S, alu_pkg::OP_DIV_U}) rop = alu_pkg::OP_MULH_SU;
			ra = $random(seed);
			rb = $random(seed);
			ri = 16'($random(seed));
			if (rop inside {alu_pkg::OP_CMPI_EQ, alu_pkg::OP_CMPI_NE}) ri[15] = 1'b0;
			op_valid_i <= 1'b1;
			op_code_i <= rop;
			opnd_a_i <= ra;
			opnd_b_i <= rb;
			imm_i <= ri;
			dest_idx_i <= 5'($random(seed));
			exp_q.push_back(calc(rop, ra, rb, ri));
			@(negedge clk_sys_i);
			if (k > 0) begin
				check(32'(result_valid_o), 32'h0000_0001);
				check(result_o, exp_q.pop_front());
			end
		end
		@(posedge clk_sys_i);
		op_valid_i <= 1'b0;
		@(negedge clk_sys_i);
		check(result_o, exp_q.pop_front());
		// Offers made while a divide runs are ignored.
		@(posedge clk_sys_i);
		op_valid_i <= 1'b1;
		op_code_i <= alu_pkg::OP_DIV_U;
		opnd_a_i <= 32'h0000_0064;
		opnd_b_i <= 32'h0000_0007;
		@(posedge clk_sys_i);
		op_code_i <= alu_pkg::OP_SUB;
		repeat (10) @(posedge clk_sys_i);
		op_valid_i <= 1'b0;
		n = 0;
		repeat (40) begin
			@(negedge clk_sys_i);
			if (result_valid_o === 1'b1) n++;
		end
		check(32'(n), 32'h0000_0001);
		check(result_o, calc(alu_pkg::OP_DIV_U, 32'h0000_0064, 32'h0000_0007, 16'h0000));
		// Reset in the middle of a divide.
		@(posedge clk_sys_i);
		op_valid_i <= 1'b1;
		op_code_i <= alu_pkg::OP_DIV_S;
		repeat (5) @(posedge clk_sys_i);
		arst_n_i <= 1'b0;
		op_valid_i <= 1'b0;
		@(negedge clk_sys_i);
		check({30'h0000_0000, ready_o, result_valid_o}, 32'h0000_0002);
		check(result_o, 32'h0000_0000);
		test_done();
	end
endmodule // test_integer_alu

bind integer_alu integer_alu_chk #(.DATA_W(DATA_W), .IMM_W(IMM_W), .DEST_W(DEST_W))
	u_integer_alu_chk (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .op_valid_i(op_valid_i),
	.op_code_i(op_code_i), .opnd_a_i(opnd_a_i), .opnd_b_i(opnd_b_i), .imm_i(imm_i),
	.dest_idx_i(dest_idx_i), .ready_o(ready_o), .result_valid_o(result_valid_o),
	.result_o(result_o), .result_dest_o(result_dest_o));
`default_nettype wire
